// ### pkg/ifc_pkg.sv
// Constants and types for the IF frequency counter
package ifc_pkg;
  localparam logic [7:0] IFC_ADDR_CONTROL = 8'h23;
  localparam logic [7:0] IFC_ADDR_MODE    = 8'h22;
  localparam logic [7:0] IFC_ADDR_GATE    = 8'h24;
  localparam logic [7:0] IFC_ADDR_COUNT   = 8'h25;
  localparam int         IFC_CLEAR_BIT    = 0;
  localparam int         IFC_START_BIT    = 1;
  localparam logic [3:0] IFC_MODE_RESET   = 4'h0;
  localparam logic [15:0] IFC_COUNT_MAX   = 16'hffff;
  localparam int         IFC_SYS_HZ       = 100_000_000;
  localparam int         IFC_TICK_HZ      = 1_000;
  localparam int         IFC_TICK_CYCLES  = IFC_SYS_HZ / IFC_TICK_HZ;
  localparam logic [3:0] IFC_GATE_1MS     = 4'h1;
  localparam logic [3:0] IFC_GATE_4MS     = 4'h4;
  localparam logic [3:0] IFC_GATE_8MS     = 4'h8;

  typedef enum logic [1:0] {GATE_T1, GATE_T4, GATE_T8, GATE_OPEN} ifc_gate_t;
  typedef enum logic [1:0] {FN_OFF, FN_AM_AM, FN_FM_HALF, FN_FM_AM} ifc_func_t;

  typedef struct packed {
    ifc_func_t function_select;
    ifc_gate_t gate_time_select;
  } ifc_mode_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [3:0] wdata;
  } ifc_wr_t;
endpackage

// ### verif/ifc_counter_properties.sv
// Port checker for the IF counter
`timescale 1ns/10ps
module ifc_counter_properties
  import ifc_pkg::*;
#(
  parameter int TICK_CYCLES = IFC_TICK_CYCLES
)(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_halt,
  input wire ifc_wr_t     i_wr,
  input wire logic [3:0]  o_mode,
  input wire logic        o_gate_open_flag,
  input wire logic [15:0] o_count_value_register,
  input wire logic        o_port1c_bit2_gpio,
  input wire logic        o_port1c_bit3_gpio
);
  localparam int MAXG = 9 * TICK_CYCLES + 4;
  logic [31:0] flag_len;
  // Cycles the gate flag has stood high so far
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !o_gate_open_flag)
      flag_len <= '0;
    else
      flag_len <= flag_len + 32'h1;
  end
  wire mw = i_wr.wr && i_wr.addr == 8'h22;
  wire clr = i_wr.wr && i_wr.addr == 8'h23 && i_wr.wdata[0];
  wire idle = !o_gate_open_flag && o_mode[1:0] != 2'h3 && !clr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence start_s;
    i_wr.wr && i_wr.addr == 8'h23 && i_wr.wdata[1] && o_mode[1:0] != 2'h3;
  endsequence
  sequence gate_s;
    o_gate_open_flag[*8];
  endsequence
  flag_on_start_a: assert property (start_s |=> gate_s)
    else $error("gate flag did not follow start");
  gate_close_a: assert property ($rose(o_gate_open_flag) |-> gate_s)
    else $error("timed gate too short");
  gate_max_a: assert property (o_gate_open_flag |-> flag_len < 32'(MAXG))
    else $error("timed gate too long");
  gate_min_a: assert property ($fell(o_gate_open_flag) |-> flag_len > 32'(TICK_CYCLES))
    else $error("timed gate ended early");
  clear_zero_a: assert property (clr |=> o_count_value_register == 16'h0)
    else $error("clear did not zero count");
  count_sat_a: assert property (o_count_value_register == 16'hffff && !clr |=>
    o_count_value_register == 16'hffff) else $error("count left full scale");
  step_one_a: assert property (!clr |=>
    o_count_value_register - $past(o_count_value_register) <= 16'h1)
    else $error("count jumped");
  idle_hold_a: assert property (idle[*4] |=> $stable(o_count_value_register))
    else $error("count moved with gate shut");
  pin_select_a: assert property (o_mode == $past(o_mode) |->
    o_port1c_bit2_gpio == (o_mode[3:2] != 2'h1) && o_port1c_bit3_gpio == (o_mode[3] == 1'b0))
    else $error("pin use does not match function");
  mode_write_a: assert property (mw && !i_halt |=> o_mode == $past(i_wr.wdata))
    else $error("mode write lost");
  halt_keep_a: assert property (mw && i_halt |=> $stable(o_mode))
    else $error("mode changed in halt");
  reset_init_a: assert property (disable iff (1'b0) i_srst |=> o_mode == 4'h0 &&
    !o_gate_open_flag && o_port1c_bit2_gpio && o_port1c_bit3_gpio) else $error("reset state wrong");
endmodule
bind ifc_counter ifc_counter_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_halt(i_halt), .i_wr(i_wr), .o_mode(o_mode),
  .o_gate_open_flag(o_gate_open_flag), .o_count_value_register(o_count_value_register),
  .o_port1c_bit2_gpio(o_port1c_bit2_gpio), .o_port1c_bit3_gpio(o_port1c_bit3_gpio));

// ### verif/ifc_if_source.sv
// Tuner IF model: free-running square waves
`timescale 1ns/10ps
module ifc_if_source
(
  input  wire logic i_clk,
  output logic      o_am,
  output logic      o_fm
);
  logic [2:0] phase = 3'h0;
  // Two cycles per level at least, as the pins need
  always @(posedge i_clk)
    phase <= phase + 3'h1;
  assign o_am = phase[1];
  assign o_fm = phase[2];
endmodule

// ### verif/test_ifc_counter.sv
// Self-checking bench for the IF counter
`timescale 1ns/10ps
module test_ifc_counter;
  import ifc_pkg::*;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_halt = 1'b0, am, fm, flg, g2, g3;
  ifc_wr_t     i_wr = '0;
  logic [3:0]  o_mode;
  logic [15:0] cnt, v;
  int          err_count = 0, n_tests = 0, cyc = 0;
  logic [19:0] rows [6] = '{20'h4000a, 20'h50028, 20'h60050, 20'ha0014, 20'he0028, 20'h20000};
  ifc_if_source src (.i_clk, .o_am(am), .o_fm(fm));
  ifc_counter #(.TICK_CYCLES(40)) uut (.i_clk, .i_srst, .i_halt, .i_wr, .i_am_if_input(am),
    .i_fm_if_input(fm), .o_mode, .o_gate_open_flag(flg), .o_count_value_register(cnt),
    .o_port1c_bit2_gpio(g2), .o_port1c_bit3_gpio(g3));
  always #5 i_clk = ~i_clk;
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(negedge i_clk);
    i_wr = '{1'b1, a, d};
    @(negedge i_clk);
    i_wr.wr = 1'b0;
  endtask
  task automatic chk(input string s, input logic [16:0] e, g, input int t);
    n_tests++;
    if ($isunknown(g) || g + t < e || g > e + t)
    begin
      err_count++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    chk("gpio", 3, {g2, g3}, 0);
    foreach (rows[i])
    begin
      wr(8'h22, rows[i][19:16]);
      repeat (8) @(negedge i_clk);
      wr(8'h23, 4'h1);
      wr(8'h23, 4'h2);
      chk("flag", 1, flg, 0);
      for (int k = 0; k < 500 && flg !== 1'b0; k++) @(negedge i_clk);
      chk("flag end", 0, flg, 0);
      chk("mode", rows[i][19:16], o_mode, 0);
      chk("pins", {rows[i][19:18] != 2'h1, !rows[i][19]}, {g2, g3}, 0);
      chk("count", rows[i][15:0], cnt, 1);
    end
    // Open gate runs without start; start is never sent here
    wr(8'h22, 4'h7);
    repeat (40) @(negedge i_clk);
    chk("open", 10, cnt, 2);
    wr(8'h23, 4'h1);
    chk("clear", 0, cnt, 0);
    wr(8'h22, 4'h3);
    repeat (4) @(negedge i_clk);
    v = cnt;
    repeat (40) @(negedge i_clk);
    chk("stop", v, cnt, 0);
    wr(8'h22, 4'h4);
    repeat (4) @(negedge i_clk);
    v = cnt;
    repeat (40) @(negedge i_clk);
    chk("shut", v, cnt, 0);
    i_halt = 1'b1;
    wr(8'h22, 4'h9);
    chk("halt", 4, o_mode, 0);
    i_halt = 1'b0;
    wr(8'h24, 4'hf);
    chk("unmap", 4, o_mode, 0);
    i_srst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
    chk("reset", 0, {o_mode, flg}, 0);
    chk("reset pins", 3, {g2, g3}, 0);
    end_sim();
  end
endmodule

// ### verilog/ifc_counter.sv
// IF frequency counter: pin select, gate timing, saturating count
`timescale 1ns/10ps
module ifc_counter
  import ifc_pkg::*;
#(
  parameter int TICK_CYCLES = IFC_TICK_CYCLES
)(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_halt,
  input  wire ifc_wr_t     i_wr,
  input  wire logic        i_am_if_input,
  input  wire logic        i_fm_if_input,
  output logic [3:0]       o_mode,
  output logic             o_gate_open_flag,
  output logic [15:0]      o_count_value_register,
  output logic             o_port1c_bit2_gpio,
  output logic             o_port1c_bit3_gpio
);

  ifc_mode_t   mode;
  logic        am_s1;
  logic        am_s2;
  logic        fm_s1;
  logic        fm_s2;
  logic        sel_prev;
  logic        half;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        gate;
  logic        armed;
  logic [3:0]  ms_left;
  logic [15:0] count;
  logic        count_en;
  logic        wr_mode;
  logic        wr_ctrl;
  logic        sel_in;
  logic        edge_in;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders shared by pin ownership and counting
  function automatic logic am_pin_used(input ifc_func_t fn);
    am_pin_used = (fn == FN_AM_AM);
  endfunction

  function automatic logic fm_pin_used(input ifc_func_t fn);
    fm_pin_used = (fn == FN_FM_HALF) || (fn == FN_FM_AM);
  endfunction

  function automatic logic counting_fn(input ifc_func_t fn);
    counting_fn = am_pin_used(fn) || fm_pin_used(fn);
  endfunction

  // Gate length in ticks for each timed code
  function automatic logic [3:0] gate_ms(input ifc_gate_t code);
    case (code)
      GATE_T1: gate_ms = IFC_GATE_1MS;
      GATE_T4: gate_ms = IFC_GATE_4MS;
      default: gate_ms = IFC_GATE_8MS;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode; unmapped addresses are ignored
  assign wr_mode = i_wr.wr && (i_wr.addr == IFC_ADDR_MODE);
  assign wr_ctrl = i_wr.wr && (i_wr.addr == IFC_ADDR_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register; halt freezes it, reset returns pins to inputs
  // pins back to general input
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      mode <= ifc_mode_t'(IFC_MODE_RESET);
    else if (wr_mode && !i_halt)
      mode <= ifc_mode_t'(i_wr.wdata);
  end

  // Mode reads back as one nibble
  assign o_mode             = mode;
  // a pin the function leaves unused stays an input
  assign o_port1c_bit2_gpio = !am_pin_used(mode.function_select);
  assign o_port1c_bit3_gpio = !fm_pin_used(mode.function_select);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Tuner pins are asynchronous; only the second flop is read
  always_ff @(posedge i_clk)
  begin
    am_s1 <= i_am_if_input;
    am_s2 <= am_s1;
    fm_s1 <= i_fm_if_input;
    fm_s2 <= fm_s1;
  end

  // pin chosen by function code
  // Deselected input reads low, so counting stops
  always_comb
  begin
    case (mode.function_select)
      FN_AM_AM:   sel_in = am_s2;
      FN_FM_HALF: sel_in = fm_s2;
      FN_FM_AM:   sel_in = fm_s2;
      default:    sel_in = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sel_prev <= 1'b0;
    else
      sel_prev <= sel_in;
  end

  // Edge reference; a level already high at gate open adds no count
  // rising edges counted
  assign edge_in = sel_in && !sel_prev;

  ////////////////////////////////////////////////////////////////////////////
  // 1-kHz timing tick divided from the system clock
  // Free-running, so a start waits up to one tick period for the gate
  // gate timing from divided clock
  always_ff @(posedge i_clk)
  begin
    if (i_srst || tick_cnt == 32'(TICK_CYCLES - 1))
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // One-cycle strobe at the end of each period
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Gate control
  // Priority: open code, start, tick, close
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      gate    <= 1'b0;
      armed   <= 1'b0;
      ms_left <= 4'h0;
    end
    // open code opens gate at once
    else if (mode.gate_time_select == GATE_OPEN)
    begin
      gate  <= 1'b1;
      armed <= 1'b0;
      // Drop any timed remainder so a later timed code shuts the gate
      ms_left <= 4'h0;
    end
    // A restart during a timed gate shuts it until the next tick
    // start arms, next tick opens
    else if (wr_ctrl && i_wr.wdata[IFC_START_BIT])
    begin
      gate  <= 1'b0;
      armed <= 1'b1;
    end
    else if (armed && tick)
    begin
      armed <= 1'b0;
      gate  <= 1'b1;
      ms_left <= gate_ms(mode.gate_time_select);
    end
    else if (gate && ms_left == 4'h0)
      gate <= 1'b0;
    // Last tick of the window drops gate and flag together
    else if (gate && tick)
    begin
      ms_left <= ms_left - 4'h1;
      if (ms_left == 4'h1)
        gate <= 1'b0;
    end
  end

  // flag covers armed and timed gate
  // Remainder test keeps the flag low while an open gate is being shut
  assign o_gate_open_flag = armed
                            || (gate && ms_left != 4'h0 && mode.gate_time_select != GATE_OPEN);

  ////////////////////////////////////////////////////////////////////////////
  // FM halving toggle
  // Toggle restarts outside FM-half mode, so the first FM edge after entering it is not counted
  // divide by two in FM-half mode only
  always_ff @(posedge i_clk)
  begin
    if (i_srst || mode.function_select != FN_FM_HALF)
      half <= 1'b0;
    else if (gate && edge_in)
      half <= ~half;
  end

  assign count_en = gate && edge_in && counting_fn(mode.function_select)
                    && (mode.function_select != FN_FM_HALF || half);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating counter
  always_ff @(posedge i_clk)
  begin
    if (i_srst || (wr_ctrl && i_wr.wdata[IFC_CLEAR_BIT]))
      count <= '0;
    // Only enabled edges advance the count
    else if (count_en)
    begin
      if (count != IFC_COUNT_MAX)
        count <= count + 16'h1;
    end
  end

  // Straight from the flop; a read has nothing to disturb
  // count visible, read has no effect
  assign o_count_value_register = count;

endmodule
